// ===== hdl/rpioc_map.vh
`ifndef RPIOC_MAP_VH
`define RPIOC_MAP_VH
// ----------------------------------------------------------------------------
// Remote parallel I/O control constants
// ----------------------------------------------------------------------------
// Input function codes (4 bits per input).
`define RPIOC_FN_NONE      4'h0
`define RPIOC_FN_RF        4'h1
`define RPIOC_FN_RESET     4'h2
`define RPIOC_FN_REBOOT    4'h3
`define RPIOC_FN_EXC       4'h4
`define RPIOC_FN_AUTOCO    4'h5
`define RPIOC_FN_PWR       4'h6
`define RPIOC_FN_PRESET    4'h7
// Input interpretation codes (4 bits per input).
`define RPIOC_LG_RISE_ON   4'h0
`define RPIOC_LG_FALL_ON   4'h1
`define RPIOC_LG_RISE_OFF  4'h2
`define RPIOC_LG_FALL_OFF  4'h3
`define RPIOC_LG_FALL_TOG  4'h4
`define RPIOC_LG_RISE_TOG  4'h5
`define RPIOC_LG_RISE_FALL 4'h6
`define RPIOC_LG_FALL_RISE 4'h7
`define RPIOC_LG_HI_INC    4'h8
`define RPIOC_LG_LO_INC    4'h9
`define RPIOC_LG_HI_DEC    4'ha
`define RPIOC_LG_LO_DEC    4'hb
// Output source codes (4 bits per output).
`define RPIOC_OS_NONE      4'h0
`define RPIOC_OS_REMOTE    4'h1
`define RPIOC_OS_RF        4'h2
`define RPIOC_OS_PRESET    4'h3
`define RPIOC_OS_EXC       4'h4
`define RPIOC_OS_AUTOCO    4'h5
`define RPIOC_OS_ALARM     4'h6
`define RPIOC_OS_AUDIO     4'h7
// Field widths.
`define RPIOC_CODE_W       4
`define RPIOC_SEL_W        3
// Power step repeat period.
`define RPIOC_REPEAT_NS    500000000
`define RPIOC_CLK_NS       100
`endif

// ===== hdl/rpioc_in_chan.v
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// One remote input channel: synchroniser, edge detect and interpretation.
// ----------------------------------------------------------------------------
`include "rpioc_map.vh"
module rpioc_in_chan (
   input  wire       i_mclk,       // System clock.
   input  wire       i_srst,       // Synchronous reset, active high.
   input  wire       i_pin,        // Raw remote input level.
   input  wire [3:0] i_logic,      // Interpretation code.
   output reg        o_on_pulse,   // One-cycle activation event.
   output reg        o_off_pulse,  // One-cycle deactivation event.
   output reg        o_level_act,  // Level-mode active indication.
   output reg        o_level_inc,  // Level mode means increase.
   output reg        o_level_dec   // Level mode means decrease.
);
   reg  sync1_r;                   // First synchroniser stage.
   reg  sync2_r;                   // Second synchroniser stage.
   reg  prev_r;                    // Previous synchronised level.
   reg  tog_r;                     // Toggle state.
   reg  tog_nxt;                   // Next toggle state.
   wire rise = sync2_r & ~prev_r;  // Rising edge of clean input.
   wire fall = ~sync2_r & prev_r;  // Falling edge of clean input.

   // ----------------------------------------------------------------------
   // Synchroniser and edge history
   // ----------------------------------------------------------------------
   // Two stages guard against metastability; only one edge per transition.
   always @(posedge i_mclk) begin
      if (i_srst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r  <= 1'b0;
         tog_r   <= 1'b0;
      end else begin
         sync1_r <= i_pin;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
         tog_r   <= tog_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Interpretation
   // ----------------------------------------------------------------------
   // Pulses are combinational from registered edges, so each lasts one cycle.
   always @* begin
      o_on_pulse  = 1'b0;
      o_off_pulse = 1'b0;
      o_level_act = 1'b0;
      o_level_inc = 1'b0;
      o_level_dec = 1'b0;
      tog_nxt     = tog_r;
      case (i_logic)
         `RPIOC_LG_RISE_ON:   o_on_pulse  = rise;
         `RPIOC_LG_FALL_ON:   o_on_pulse  = fall;
         `RPIOC_LG_RISE_OFF:  o_off_pulse = rise;
         `RPIOC_LG_FALL_OFF:  o_off_pulse = fall;
         `RPIOC_LG_FALL_TOG, `RPIOC_LG_RISE_TOG: begin
            // The first qualifying edge deactivates for falling mode, and
            // activates for rising mode, as the two variants are described.
            if ((i_logic == `RPIOC_LG_FALL_TOG) ? fall : rise) begin
               tog_nxt     = ~tog_r;
               o_on_pulse  = (i_logic == `RPIOC_LG_RISE_TOG) ? ~tog_r : tog_r;
               o_off_pulse = ~o_on_pulse;
            end
         end
         `RPIOC_LG_RISE_FALL: begin
            o_on_pulse  = rise;
            o_off_pulse = fall;
         end
         `RPIOC_LG_FALL_RISE: begin
            o_on_pulse  = fall;
            o_off_pulse = rise;
         end
         `RPIOC_LG_HI_INC: begin
            o_level_act = sync2_r;
            o_level_inc = 1'b1;
         end
         `RPIOC_LG_LO_INC: begin
            o_level_act = ~sync2_r;
            o_level_inc = 1'b1;
         end
         `RPIOC_LG_HI_DEC: begin
            o_level_act = sync2_r;
            o_level_dec = 1'b1;
         end
         `RPIOC_LG_LO_DEC: begin
            o_level_act = ~sync2_r;
            o_level_dec = 1'b1;
         end
         default: o_on_pulse = 1'b0;
      endcase
   end
endmodule // rpioc_in_chan

// ===== hdl/rpioc_top.v
`timescale 1ns/10ps
`include "rpioc_map.vh"
module rpioc_top #(
   parameter N_IN        = 10,                // Number of remote inputs.
   parameter N_OUT       = 16,                // Number of remote outputs.
   parameter N_ALARM     = 8,                 // Number of selectable alarms.
   parameter N_PRESET    = 8,                 // Number of presets.
   parameter REPEAT_CYC  = `RPIOC_REPEAT_NS / `RPIOC_CLK_NS // Repeat period.
) (
   input  wire                           i_mclk,          // 10 MHz clock.
   input  wire                           i_srst,          // Sync reset, high.
   input  wire [N_IN-1:0]                i_remote_in,     // Remote input pins.
   input  wire [N_IN*4-1:0]              i_in_func,       // Function per input.
   input  wire [N_IN*4-1:0]              i_in_logic,      // Logic per input.
   input  wire [N_IN*3-1:0]              i_in_arg,        // Preset index per input.
   input  wire [N_IN-1:0]                i_in_exempt,     // Accepted when local.
   input  wire                           i_remote_en,     // Remote selected.
   input  wire [N_OUT*4-1:0]             i_out_src,       // Source per output.
   input  wire [N_OUT*3-1:0]             i_out_arg,       // Source index.
   input  wire [N_OUT-1:0]               i_out_pol,       // 1: low when false.
   input  wire                           i_rf_enabled,    // RF power stage on.
   input  wire                           i_exc_is_b,      // Exciter B in use.
   input  wire                           i_autoco_en,     // Changeover state.
   input  wire [N_ALARM-1:0]             i_alarms,        // Alarm conditions.
   input  wire [3:0]                     i_audio_active,  // Audio path active.
   input  wire [2:0]                     i_preset_now,    // Active preset.
   output reg                            o_rf_on_cmd,     // RF on command.
   output reg                            o_rf_off_cmd,    // RF off command.
   output reg                            o_sys_reset,     // System reset pulse.
   output reg                            o_host_reset,    // Host board reset.
   output reg                            o_exc_sel_a,     // Select exciter A.
   output reg                            o_exc_sel_b,     // Select exciter B.
   output reg                            o_autoco_tog,    // Toggle changeover.
   output reg                            o_pwr_up,        // Power up 1 pct.
   output reg                            o_pwr_dn,        // Power down 1 pct.
   output reg                            o_preset_load,   // Load preset: edge pulse, or level while a level input is active.
   output reg  [2:0]                     o_preset_idx,    // Preset to load.
   output reg  [N_OUT-1:0]               o_out_oe         // Pull pin low.
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   localparam CW = 24;                         // Repeat counter width.
   localparam [CW-1:0] REP = REPEAT_CYC[CW-1:0]; // Repeat period in cycles.
   wire [N_IN-1:0] on_p;                       // Activation events.
   wire [N_IN-1:0] off_p;                      // Deactivation events.
   wire [N_IN-1:0] lvl;                        // Level-mode active.
   wire [N_IN-1:0] lvl_inc;                    // Level mode increases.
   wire [N_IN-1:0] lvl_dec;                    // Level mode decreases.
   reg  [N_IN-1:0] hold_r;                     // Edge-mode power held state.
   reg  [CW-1:0]   rep_r;                      // Repeat countdown.
   reg  [CW-1:0]   rep_nxt;                    // Next countdown.
   reg             pwr_act_r;                  // Power input was active.
   reg  [N_IN-1:0] hold_nxt;                   // Next held states.
   reg             win_act;                    // A power input is active.
   reg             win_up;                     // Winner direction is up.
   reg             win_new;                    // Winner just activated.
   reg             rf_on_nxt, rf_off_nxt, rst_nxt, hrst_nxt, exa_nxt, exb_nxt, aco_nxt, ld_nxt;
   reg  [2:0]      pidx_nxt;                   // Next preset index.
   reg  [N_OUT-1:0] oe_nxt;                    // Next output enables.
   integer         k;                          // Input loop index.
   integer         j;                          // Output loop index, kept apart from k.

   // Returns the 4-bit code of field n from a packed vector.
   function [3:0] code4;
      input [N_OUT*4-1:0] v;
      input integer       n;
      begin
         code4 = v[n*4 +: 4];
      end
   endfunction

   // ----------------------------------------------------------------------
   // Input channels
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < N_IN; g = g + 1) begin : g_in
         rpioc_in_chan u_chan (
            .i_mclk      (i_mclk),
            .i_srst      (i_srst),
            .i_pin       (i_remote_in[g]),
            .i_logic     (i_in_logic[g*4 +: 4]),
            .o_on_pulse  (on_p[g]),
            .o_off_pulse (off_p[g]),
            .o_level_act (lvl[g]),
            .o_level_inc (lvl_inc[g]),
            .o_level_dec (lvl_dec[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   // Events are qualified by remote selection and function; a power input
   // is active while its level or its edge-held state says so.
   always @* begin
      rf_on_nxt  = 1'b0;
      rf_off_nxt = 1'b0;
      rst_nxt    = 1'b0;
      hrst_nxt   = 1'b0;
      exa_nxt    = 1'b0;
      exb_nxt    = 1'b0;
      aco_nxt    = 1'b0;
      ld_nxt     = 1'b0;
      pidx_nxt   = o_preset_idx;
      hold_nxt = hold_r;
      win_act = 1'b0;
      win_up  = 1'b0;
      win_new = 1'b0;
      for (k = N_IN - 1; k >= 0; k = k - 1) begin
         if (i_remote_en || i_in_exempt[k]) begin
            case (i_in_func[k*4 +: 4])
               `RPIOC_FN_RF: begin
                  rf_on_nxt  = rf_on_nxt | on_p[k];
                  rf_off_nxt = rf_off_nxt | off_p[k];
               end
               `RPIOC_FN_RESET:  rst_nxt  = rst_nxt | on_p[k];
               `RPIOC_FN_REBOOT: hrst_nxt = hrst_nxt | on_p[k];
               `RPIOC_FN_EXC: begin
                  exa_nxt = exa_nxt | on_p[k];
                  exb_nxt = exb_nxt | off_p[k];
               end
               `RPIOC_FN_AUTOCO: aco_nxt = aco_nxt | on_p[k];
               `RPIOC_FN_PRESET: begin
                  if (on_p[k] || lvl[k]) begin
                     ld_nxt   = 1'b1;
                     pidx_nxt = i_in_arg[k*3 +: 3];
                  end
               end
               `RPIOC_FN_PWR: begin
                  // Edge modes: on holds the step, off releases it; the
                  // argument bit 0 picks decrease for edge modes.
                  if (on_p[k]) hold_nxt[k] = 1'b1;
                  if (off_p[k]) hold_nxt[k] = 1'b0;
                  if (lvl[k] || hold_nxt[k]) begin
                     win_act = 1'b1;
                     win_up  = lvl[k] ? lvl_inc[k] : ~i_in_arg[k*3];
                     win_new = on_p[k] | (lvl[k] & ~pwr_act_r);
                  end
               end
               // An unassigned input issues nothing and cannot keep a
               // power step held from an earlier assignment.
               default: hold_nxt[k] = 1'b0;
            endcase
         end else begin
            hold_nxt[k] = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Power step repeat timer
   // ----------------------------------------------------------------------
   // First step at activation, then one per half second while held.
   always @* begin
      rep_nxt = rep_r;
      if (!win_act) begin
         rep_nxt = REP - {{(CW-1){1'b0}}, 1'b1};
      end else if (win_new || !pwr_act_r) begin
         rep_nxt = REP - {{(CW-1){1'b0}}, 1'b1};
      end else if (rep_r == {CW{1'b0}}) begin
         rep_nxt = REP - {{(CW-1){1'b0}}, 1'b1};
      end else begin
         rep_nxt = rep_r - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // ----------------------------------------------------------------------
   // Output selection
   // ----------------------------------------------------------------------
   // Open-collector pins: enable pulls low, otherwise the pin floats high.
   always @* begin
      oe_nxt = {N_OUT{1'b0}};
      for (j = 0; j < N_OUT; j = j + 1) begin
         case (code4(i_out_src, j))
            `RPIOC_OS_REMOTE: oe_nxt[j] = i_remote_en ^ i_out_pol[j];
            `RPIOC_OS_RF:     oe_nxt[j] = i_rf_enabled ^ i_out_pol[j];
            `RPIOC_OS_PRESET:
               oe_nxt[j] = (i_preset_now == i_out_arg[j*3 +: 3]) ^ i_out_pol[j];
            `RPIOC_OS_EXC:    oe_nxt[j] = ~i_exc_is_b ^ i_out_pol[j];
            `RPIOC_OS_AUTOCO: oe_nxt[j] = i_autoco_en ^ i_out_pol[j];
            `RPIOC_OS_ALARM:
               oe_nxt[j] = i_alarms[i_out_arg[j*3 +: 3]] ^ i_out_pol[j];
            `RPIOC_OS_AUDIO:
               oe_nxt[j] = i_audio_active[i_out_arg[j*3 +: 2]] ^ i_out_pol[j];
            default:          oe_nxt[j] = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // All command outputs are registered one-cycle pulses, except o_preset_load, high while a level preset input is active.
   always @(posedge i_mclk) begin
      if (i_srst) begin
         hold_r        <= {N_IN{1'b0}};
         rep_r         <= {CW{1'b0}};
         pwr_act_r     <= 1'b0;
         o_rf_on_cmd   <= 1'b0;
         o_rf_off_cmd  <= 1'b0;
         o_sys_reset   <= 1'b0;
         o_host_reset  <= 1'b0;
         o_exc_sel_a   <= 1'b0;
         o_exc_sel_b   <= 1'b0;
         o_autoco_tog  <= 1'b0;
         o_pwr_up      <= 1'b0;
         o_pwr_dn      <= 1'b0;
         o_preset_load <= 1'b0;
         o_preset_idx  <= 3'h0;
         o_out_oe      <= {N_OUT{1'b0}};
      end else begin
         hold_r        <= hold_nxt;
         rep_r         <= rep_nxt;
         pwr_act_r     <= win_act;
         o_rf_on_cmd   <= rf_on_nxt;
         o_rf_off_cmd  <= rf_off_nxt;
         o_sys_reset   <= rst_nxt;
         o_host_reset  <= hrst_nxt;
         o_exc_sel_a   <= exa_nxt;
         o_exc_sel_b   <= exb_nxt;
         o_autoco_tog  <= aco_nxt;
         o_pwr_up      <= win_act && win_up &&
                          (!pwr_act_r || rep_r == {CW{1'b0}});
         o_pwr_dn      <= win_act && !win_up &&
                          (!pwr_act_r || rep_r == {CW{1'b0}});
         o_preset_load <= ld_nxt;
         o_preset_idx  <= pidx_nxt;
         o_out_oe      <= oe_nxt;
      end
   end
endmodule // rpioc_top

// ===== dv/rpioc_top_props.sv
`timescale 1ns/10ps
`include "rpioc_map.vh"
// -------------------------------------------------------------
// Port checker: status outputs and command paths.
// -------------------------------------------------------------
module rpioc_chk #(
   parameter N_IN    = 10, // Remote inputs.
   parameter N_OUT   = 16, // Remote outputs.
   parameter N_ALARM = 8   // Alarm sources.
) (
   input wire               i_mclk,       // Clock.
   input wire               i_srst,       // Reset.
   input wire [N_IN-1:0]    i_remote_in,  // Pins.
   input wire [N_IN*4-1:0]  i_in_func,    // Functions.
   input wire [N_IN*4-1:0]  i_in_logic,   // Interpretations.
   input wire [N_IN-1:0]    i_in_exempt,  // Exempt inputs.
   input wire               i_remote_en,  // Remote mode.
   input wire [N_OUT*4-1:0] i_out_src,    // Output sources.
   input wire [N_OUT*3-1:0] i_out_arg,    // Output indices.
   input wire [N_OUT-1:0]   i_out_pol,    // Polarity.
   input wire               i_rf_enabled, // RF stage on.
   input wire [N_ALARM-1:0] i_alarms,     // Alarms.
   input wire [2:0]         i_preset_now, // Active preset.
   input wire               o_rf_on_cmd,  // RF on.
   input wire               o_rf_off_cmd, // RF off.
   input wire               o_sys_reset,  // System reset.
   input wire               o_host_reset, // Host reset.
   input wire               o_pwr_up,     // Power up.
   input wire               o_pwr_dn,     // Power down.
   input wire [N_OUT-1:0]   o_out_oe      // Pull-downs.
);
   default clocking cb @(posedge i_mclk);
   endclocking
   // Reset as seen at the last edge: the first edge after release still
   // clears the outputs, so the next-cycle checks must skip it.
   logic srst_q = 1'b1;
   always @(posedge i_mclk) srst_q <= i_srst;
   default disable iff (i_srst || srst_q);
   // Any command leaving the block; the exciter, changeover and preset paths are left out.
   wire any_cmd = o_rf_on_cmd | o_rf_off_cmd | o_sys_reset | o_host_reset | o_pwr_up | o_pwr_dn;
   // Input 0 set up as a remote falling-edge RF on control.
   wire rf0_cfg = i_remote_en && i_in_func[3:0] == `RPIOC_FN_RF
                  && i_in_logic[3:0] == `RPIOC_LG_FALL_ON;
   // Alarm picked by output 3.
   wire alm3 = i_alarms[i_out_arg[11:9]];
   // A fall on pin 0 held long enough to pass the synchroniser.
   sequence s_fall0;
      $fell(i_remote_in[0]) && rf0_cfg ##1 (!i_remote_in[0] && rf0_cfg) [*2];
   endsequence
   property p_rf_on0;
      s_fall0 |-> ##[0:3] o_rf_on_cmd;
   endproperty
   a_rf_on0: assert property (p_rf_on0) else $error("rf on missing");
   property p_local;
      (!i_remote_en && i_in_exempt == '0) [*6] |-> !any_cmd;
   endproperty
   a_local: assert property (p_local) else $error("command while local");
   property p_pwr_excl;
      !(o_pwr_up && o_pwr_dn);
   endproperty
   a_pwr_excl: assert property (p_pwr_excl) else $error("up and down together");
   property p_pwr_gap;
      o_pwr_dn |=> !o_pwr_dn [*2];
   endproperty
   a_pwr_gap: assert property (p_pwr_gap) else $error("power step too soon");
   property p_out_none;
      i_out_src[3:0] == `RPIOC_OS_NONE |=> !o_out_oe[0];
   endproperty
   a_out_none: assert property (p_out_none) else $error("unassigned output driven");
   property p_out_rem;
      i_out_src[3:0] == `RPIOC_OS_REMOTE |=> o_out_oe[0] == ($past(i_remote_en) ^ $past(i_out_pol[0]));
   endproperty
   a_out_rem: assert property (p_out_rem) else $error("remote status wrong");
   property p_out_rf;
      i_out_src[7:4] == `RPIOC_OS_RF |=> o_out_oe[1] == ($past(i_rf_enabled) ^ $past(i_out_pol[1]));
   endproperty
   a_out_rf: assert property (p_out_rf) else $error("rf status wrong");
   property p_out_pre;
      i_out_src[11:8] == `RPIOC_OS_PRESET |=>
         o_out_oe[2] == (($past(i_preset_now) == $past(i_out_arg[8:6])) ^ $past(i_out_pol[2]));
   endproperty
   a_out_pre: assert property (p_out_pre) else $error("preset status wrong");
   property p_out_alm;
      i_out_src[15:12] == `RPIOC_OS_ALARM |=> o_out_oe[3] == ($past(alm3) ^ $past(i_out_pol[3]));
   endproperty
   a_out_alm: assert property (p_out_alm) else $error("alarm status wrong");
endmodule // rpioc_chk
bind rpioc_top rpioc_chk #(.N_IN(N_IN), .N_OUT(N_OUT), .N_ALARM(N_ALARM)) u_chk (
   .i_mclk(i_mclk), .i_srst(i_srst), .i_remote_in(i_remote_in), .i_in_func(i_in_func),
   .i_in_logic(i_in_logic), .i_in_exempt(i_in_exempt), .i_remote_en(i_remote_en),
   .i_out_src(i_out_src), .i_out_arg(i_out_arg), .i_out_pol(i_out_pol),
   .i_rf_enabled(i_rf_enabled), .i_alarms(i_alarms), .i_preset_now(i_preset_now),
   .o_rf_on_cmd(o_rf_on_cmd), .o_rf_off_cmd(o_rf_off_cmd), .o_sys_reset(o_sys_reset),
   .o_host_reset(o_host_reset), .o_pwr_up(o_pwr_up), .o_pwr_dn(o_pwr_dn), .o_out_oe(o_out_oe));

// ===== dv/rpioc_site_unit.sv
`timescale 1ns/10ps
// -------------------------------------------------------------
// Site remote unit: drives the input pins, reads the outputs.
// -------------------------------------------------------------
module rpioc_site_unit (
   input  wire logic [15:0] i_oe,    // Pull-down enables.
   input  wire logic        i_mclk,  // Clock.
   output logic      [9:0]  o_pins,  // Remote input levels.
   output logic      [15:0] o_sense  // Output line levels.
);
   initial o_pins = '0;
   // Each output line has a pull-up, so a released line reads high.
   assign o_sense = ~i_oe;
   // Set all pins just after an edge; the caller holds them long
   // enough that the synchroniser cannot miss a level.
   task automatic drive(input logic [9:0] v);
      @(posedge i_mclk);
      o_pins <= v;
   endtask
endmodule // rpioc_site_unit

// ===== dv/tb_rpioc_top.sv
`timescale 1ns/10ps
`include "rpioc_map.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
   $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_rpioc_top;
   logic        i_mclk = 0, i_srst = 1, rem_en = 1, rf_en = 0, exc_b = 0, aco = 0;
   logic [39:0] func = '0, lgc = '0;
   logic [29:0] iarg = '0;
   logic [9:0]  exempt = '0, pins, ev, seen;
   logic [63:0] osrc = '0;
   logic [47:0] oarg = '0;
   logic [15:0] opol = '0, oe, sense;
   logic [7:0]  alm = '0;
   logic [3:0]  aud = '0;
   logic [2:0]  pnow = '0, pidx;
   int          err_count = 0, cmp_count = 0, nup, ndn;
   // Expected {on, off} for four edges (rise first), per edge code.
   localparam logic [7:0] EDGE_TAB [8] = '{8'h22, 8'h88, 8'h11, 8'h44, 8'h84, 8'h12, 8'h66, 8'h99};
   // Expected command for a rising activation, per function code.
   localparam logic [9:0] FN_EV [8] = '{10'h000, 10'h200, 10'h080, 10'h040, 10'h020, 10'h008,
                                         10'h000, 10'h001};
   // Expected command for a falling deactivation, per function code.
   localparam logic [9:0] FN_OFF [8] = '{10'h000, 10'h100, 10'h000, 10'h000, 10'h010,
                                          10'h000, 10'h000, 10'h000};
   rpioc_top #(.REPEAT_CYC(20)) dut (
      .i_mclk(i_mclk), .i_srst(i_srst), .i_remote_in(pins), .i_in_func(func), .i_in_logic(lgc),
      .i_in_arg(iarg), .i_in_exempt(exempt), .i_remote_en(rem_en), .i_out_src(osrc),
      .i_out_arg(oarg), .i_out_pol(opol), .i_rf_enabled(rf_en), .i_exc_is_b(exc_b),
      .i_autoco_en(aco), .i_alarms(alm), .i_audio_active(aud), .i_preset_now(pnow),
      .o_rf_on_cmd(ev[9]), .o_rf_off_cmd(ev[8]), .o_sys_reset(ev[7]), .o_host_reset(ev[6]),
      .o_exc_sel_a(ev[5]), .o_exc_sel_b(ev[4]), .o_autoco_tog(ev[3]), .o_pwr_up(ev[2]),
      .o_pwr_dn(ev[1]), .o_preset_load(ev[0]), .o_preset_idx(pidx), .o_out_oe(oe));
   rpioc_site_unit site (.i_oe(oe), .i_mclk(i_mclk), .o_pins(pins), .o_sense(sense));
   initial forever #50 i_mclk = ~i_mclk;
   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   // Gather every command pulse over n cycles; pulses last one cycle.
   task automatic watch(input int n);
      seen = '0;
      repeat (n) begin
         @(posedge i_mclk);
         #1 seen |= ev;
      end
   endtask
   task automatic do_reset;
      i_srst <= 1;
      cyc(16);
      i_srst <= 0;
      cyc(6);
   endtask
   // Expected pull-down of output k from the status inputs.
   function automatic logic exp_oe(input int k);
      logic [2:0] a;
      logic       c;
      a = oarg[k*3+:3];
      case (osrc[k*4+:4])
         `RPIOC_OS_REMOTE: c = rem_en;
         `RPIOC_OS_RF:     c = rf_en;
         `RPIOC_OS_PRESET: c = (pnow == a);
         `RPIOC_OS_EXC:    c = !exc_b;
         `RPIOC_OS_AUTOCO: c = aco;
         `RPIOC_OS_ALARM:  c = alm[a];
         `RPIOC_OS_AUDIO:  c = aud[a[1:0]];
         default:          return 1'b0;
      endcase
      return c ^ opol[k];
   endfunction
   // Expected command for a rising activation; edge power steps by arg bit 0.
   function automatic logic [9:0] exp_on(input int f);
      if (f == `RPIOC_FN_PWR) return iarg[0] ? 10'h002 : 10'h004;
      return FN_EV[f];
   endfunction
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // A hang costs a mismatch; the full run needs about 880 cycles.
   initial begin
      cyc(20000);
      err_count++;
      close_out;
   end
   // ----------------------------------------------------------
   // Tests
   // ----------------------------------------------------------
   initial begin
      void'($urandom(5));
      do_reset;
      // Random output mapping, polarity and status.
      repeat (30) begin
         @(posedge i_mclk);
         for (int k = 0; k < 16; k++) osrc[k*4+:4] <= 4'($urandom_range(7, 0));
         oarg <= 48'({$urandom, $urandom});
         opol <= 16'($urandom);
         rem_en <= 1'($urandom);
         rf_en <= 1'($urandom);
         exc_b <= 1'($urandom);
         aco <= 1'($urandom);
         alm <= 8'($urandom);
         aud <= 4'($urandom);
         pnow <= 3'($urandom);
         cyc(3);
         for (int k = 0; k < 16; k++) `CHK("output line", !exp_oe(k), sense[k])
      end
      rem_en <= 1;
      $display("test outputs done");
      // Every edge code on an RF input, rise then fall twice.
      func[3:0] <= `RPIOC_FN_RF;
      for (int c = 0; c < 8; c++) begin
         lgc[3:0] <= 4'(c);
         do_reset;
         for (int e = 0; e < 4; e++) begin
            site.drive(10'(e % 2 == 0));
            watch(8);
            `CHK("edge event", EDGE_TAB[c][2*e+:2], seen[9:8])
         end
      end
      $display("test edge codes done");
      // Each function once; the rise activates and the fall deactivates.
      lgc[3:0] <= `RPIOC_LG_RISE_FALL;
      for (int f = 0; f < 8; f++) begin
         func[3:0] <= 4'(f);
         iarg[2:0] <= 3'($urandom);
         cyc(2);
         site.drive(10'h001);
         watch(8);
         `CHK("function event", exp_on(f), seen)
         if (f == 7) `CHK("preset index", iarg[2:0], pidx)
         site.drive(10'h000);
         watch(8);
         `CHK("release event", FN_OFF[f], seen)
      end
      $display("test functions done");
      // Local mode blocks the input unless it is exempt.
      func[3:0] <= `RPIOC_FN_RF;
      rem_en <= 0;
      site.drive(10'h001);
      watch(8);
      `CHK("local event", 10'h000, seen)
      site.drive(10'h000);
      exempt[0] <= 1;
      cyc(6);
      site.drive(10'h001);
      watch(8);
      `CHK("exempt event", 10'h200, seen)
      site.drive(10'h000);
      {rem_en, exempt, func} <= '0;
      cyc(1);
      $display("test local done");
      // Two level power inputs: input 2 lowers, input 5 raises.
      func[11:8] <= `RPIOC_FN_PWR;
      func[23:20] <= `RPIOC_FN_PWR;
      lgc[11:8] <= `RPIOC_LG_HI_DEC;
      lgc[23:20] <= `RPIOC_LG_HI_INC;
      rem_en <= 1;
      do_reset;
      site.drive(10'h024);
      {nup, ndn} = '0;
      repeat (52) begin
         @(posedge i_mclk);
         #1 nup += ev[2];
         ndn += ev[1];
      end
      `CHK("power down steps", 3, ndn)
      `CHK("power up steps", 0, nup)
      site.drive(10'h000);
      cyc(10);
      $display("test power done");
      close_out;
   end
endmodule // tb_rpioc_top
